/* two_wire_pkg.sv */
// Shared constants and types for the two-wire slave engine
`default_nettype none
package two_wire_pkg;
   // ==============================
   // Register byte offsets
   localparam logic [4:0] OFS_NODE = 5'h00;
   localparam logic [4:0] OFS_CTRL = 5'h04;
   localparam logic [4:0] OFS_STAT = 5'h08;
   localparam logic [4:0] OFS_DATA = 5'h0C;
   localparam logic [4:0] OFS_POWER = 5'h10;
   // ==============================
   // Control field positions
   localparam int CTL_INT = 7;
   localparam int CTL_ACK = 6;
   localparam int CTL_STA = 5;
   localparam int CTL_STO = 4;
   localparam int CTL_WCOL = 3;
   localparam int CTL_EN = 2;
   localparam int CTL_IE = 0;
   localparam int PWR_SLEEP = 0;
   localparam int PWR_WOKE = 1;
   // ==============================
   // Reset values
   localparam logic [7:0] NODE_RST = 8'h00;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'hFF;
   // ==============================
   // Status codes, prescaler bits always zero
   localparam logic [7:0] PRESC_MASK = 8'hF8;
   localparam logic [7:0] ST_SR_OWN = 8'h60;
   localparam logic [7:0] ST_SR_ARB = 8'h68;
   localparam logic [7:0] ST_GC_OWN = 8'h70;
   localparam logic [7:0] ST_GC_ARB = 8'h78;
   localparam logic [7:0] ST_RX_ACK = 8'h80;
   localparam logic [7:0] ST_RX_NACK = 8'h88;
   localparam logic [7:0] ST_GC_ACK = 8'h90;
   localparam logic [7:0] ST_GC_NACK = 8'h98;
   localparam logic [7:0] ST_STOP = 8'hA0;
   localparam logic [7:0] ST_TX_OWN = 8'hA8;
   localparam logic [7:0] ST_TX_ARB = 8'hB0;
   localparam logic [7:0] ST_TX_ACK = 8'hB8;
   localparam logic [7:0] ST_TX_NACK = 8'hC0;
   localparam logic [7:0] ST_TX_LAST = 8'hC8;
   localparam logic [7:0] ST_NONE = 8'hF8;
   localparam logic [6:0] GC_ADDR = 7'h00;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   // ==============================
   // Slave phases
   typedef enum logic [2:0] {
      PH_IDLE, PH_ADDR, PH_ADDR_ACK, PH_RX, PH_RX_ACK, PH_TX, PH_TX_ACK, PH_HOLD
   } phase_t;
endpackage
`default_nettype wire

/* two_wire_slave_engine.sv */
// Two-wire bus slave engine with an Avalon-MM register port
//
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - After 0x90 clear, next byte ACK follows acknowledge_enable
// - After 0x98 clear, go not-addressed slave
// - After 0xA0 clear, go not-addressed slave
// - After 0x88 clear, go not-addressed slave
// - acknowledge_enable low: no address recognised at all
// - acknowledge_enable high: own address, general call if enabled
// - begin_condition_request set: start once bus free; latched only when set while clearing the flag from 0x88/0x98/0xA0/0xC0/0xC8
// - Status prescaler bits always read zero
// - Upper seven bits address, bit zero general call
// - Wait for address; read bit selects transmit
// - Address received: set flag, valid status
// - Lost arbitration then read-addressed reports 0xB0
// - acknowledge_enable cleared: last byte, then 0xC0/0xC8
// - After last byte, unaddressed, SDA released
// - Master ACK after last byte gives 0xC8
// - acknowledge_enable low ignores address, keeps monitoring
// - Asleep, address recognition still works and wakes
// - After wake, SCL held low until flag cleared
// - Data register need not hold last bus byte
module two_wire_slave_engine #(
   parameter int SYNC_STAGES = 3
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Avalon-MM slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Open-drain bus pins
   input wire logic sclIn,
   output logic sclOut,
   output logic sclOe,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   // Master engine hand-off and power
   input wire logic arbLost,
   output logic startRequest,
   output logic wakeUp
);
   // Fewer stages would pass a metastable level to the edge logic
   if (SYNC_STAGES < 3) $error("SYNC_STAGES must be at least 3");
   typedef struct packed {
      two_wire_pkg::phase_t ph;
      logic [SYNC_STAGES-1:0] sclS;
      logic [SYNC_STAGES-1:0] sdaS;
      logic sclF;
      logic sdaF;
      logic busy;
      logic [3:0] bitCnt;
      logic [7:0] shft;
      logic [7:0] nodeAddr;
      logic [7:0] ctrl;
      logic [7:0] dataReg;
      logic [7:0] status;
      logic gcMode;
      logic txMode;
      logic txLast;
      logic rxAck;
      logic arbHit;
      logic startPend;
      logic strq;
      logic sleepEn;
      logic woke;
      logic wakeP;
      logic sclOe;
      logic sdaOe;
      logic waitQ;
      logic [31:0] rdata;
   } state_t;
   state_t s;
   state_t n;
   logic sclAgree;
   logic sdaAgree;
   logic sclRise;
   logic sclFall;
   logic busStart;
   logic busStop;
   logic wrAcc;
   logic clrEvt;
   logic terminal;
   // ==============================
   // Bus events from the filtered pins
   // A pin level counts only once the last two stages agree
   assign sclAgree = s.sclS[SYNC_STAGES-1] == s.sclS[SYNC_STAGES-2];
   assign sdaAgree = s.sdaS[SYNC_STAGES-1] == s.sdaS[SYNC_STAGES-2];
   assign sclRise = sclAgree && s.sclS[SYNC_STAGES-1] && !s.sclF;
   assign sclFall = sclAgree && !s.sclS[SYNC_STAGES-1] && s.sclF;
   assign busStart = sdaAgree && !s.sdaS[SYNC_STAGES-1] && s.sdaF && s.sclF && !sclFall;
   assign busStop = sdaAgree && s.sdaS[SYNC_STAGES-1] && !s.sdaF && s.sclF && !sclFall;
   // Write takes effect on the edge where waitrequest is seen low
   assign wrAcc = avs_write && !s.waitQ && avs_byteenable[0];
   assign clrEvt = wrAcc && avs_address == two_wire_pkg::OFS_CTRL
                   && avs_writedata[two_wire_pkg::CTL_INT] && s.ctrl[two_wire_pkg::CTL_INT];
   assign terminal = s.status inside {two_wire_pkg::ST_RX_NACK, two_wire_pkg::ST_GC_NACK,
                     two_wire_pkg::ST_STOP, two_wire_pkg::ST_TX_NACK, two_wire_pkg::ST_TX_LAST};
   // ==============================
   // Next-state logic
   always_comb begin
      n = s;
      n.wakeP = 1'b0;
      // SYNC_STAGES-stage synchronisers; only the last two are looked at
      n.sclS = {s.sclS[SYNC_STAGES-2:0], sclIn};
      n.sdaS = {s.sdaS[SYNC_STAGES-2:0], sdaIn};
      if (sclAgree) begin
         n.sclF = s.sclS[SYNC_STAGES-1];
      end
      if (sdaAgree) begin
         n.sdaF = s.sdaS[SYNC_STAGES-1];
      end
      if (busStart) begin
         n.busy = 1'b1;
         n.startPend = 1'b0;
      end else if (busStop) begin
         n.busy = 1'b0;
      end
      if (arbLost) begin
         n.arbHit = 1'b1;
      end
      // Register port: one wait cycle per access, read data captured early
      n.waitQ = !((avs_read || avs_write) && s.waitQ);
      if (avs_read && s.waitQ) begin
         n.rdata = 32'h0000_0000;
         unique case (avs_address)
            two_wire_pkg::OFS_NODE: n.rdata[7:0] = s.nodeAddr;
            two_wire_pkg::OFS_CTRL: n.rdata[7:0] = s.ctrl;
            two_wire_pkg::OFS_STAT: begin
               // Prescaler bits masked so codes compare directly
               n.rdata[7:0] = (s.ctrl[two_wire_pkg::CTL_INT] ? s.status
                               : two_wire_pkg::ST_NONE) & two_wire_pkg::PRESC_MASK;
            end
            two_wire_pkg::OFS_DATA: n.rdata[7:0] = s.dataReg;
            two_wire_pkg::OFS_POWER: begin
               n.rdata[two_wire_pkg::PWR_SLEEP] = s.sleepEn;
               n.rdata[two_wire_pkg::PWR_WOKE] = s.woke;
            end
            default: n.rdata = 32'h0000_0000;
         endcase
      end
      if (wrAcc) begin
         unique case (avs_address)
            two_wire_pkg::OFS_NODE: n.nodeAddr = avs_writedata[7:0];
            two_wire_pkg::OFS_CTRL: begin
               n.ctrl[two_wire_pkg::CTL_ACK] = avs_writedata[two_wire_pkg::CTL_ACK];
               n.ctrl[two_wire_pkg::CTL_STA] = avs_writedata[two_wire_pkg::CTL_STA];
               n.ctrl[two_wire_pkg::CTL_STO] = avs_writedata[two_wire_pkg::CTL_STO];
               n.ctrl[two_wire_pkg::CTL_EN] = avs_writedata[two_wire_pkg::CTL_EN];
               n.ctrl[two_wire_pkg::CTL_IE] = avs_writedata[two_wire_pkg::CTL_IE];
               if (clrEvt) begin
                  // Flag clears by writing one; halt request is consumed
                  n.ctrl[two_wire_pkg::CTL_INT] = 1'b0;
                  n.ctrl[two_wire_pkg::CTL_STO] = 1'b0;
               end
            end
            two_wire_pkg::OFS_DATA: begin
               // Loading data while the bus runs would corrupt the byte
               if (s.ctrl[two_wire_pkg::CTL_INT]) begin
                  n.dataReg = avs_writedata[7:0];
                  n.ctrl[two_wire_pkg::CTL_WCOL] = 1'b0;
               end else begin
                  n.ctrl[two_wire_pkg::CTL_WCOL] = 1'b1;
               end
            end
            two_wire_pkg::OFS_POWER: begin
               n.sleepEn = avs_writedata[two_wire_pkg::PWR_SLEEP];
               if (avs_writedata[two_wire_pkg::PWR_WOKE]) n.woke = 1'b0;
            end
            default: n.rdata = s.rdata;
         endcase
      end
      // Slave sequencer; hardware flag sets come last so they win
      if (!s.ctrl[two_wire_pkg::CTL_EN]) begin
         n.ph = two_wire_pkg::PH_IDLE;
         n.sclOe = 1'b0;
         n.sdaOe = 1'b0;
      end else begin
         unique case (s.ph)
            two_wire_pkg::PH_IDLE: begin
               // Bus is monitored even while not answering
               if (busStart) begin
                  n.ph = two_wire_pkg::PH_ADDR;
                  n.bitCnt = 4'h0;
                  n.arbHit = arbLost;
               end
            end
            two_wire_pkg::PH_ADDR: begin
               if (busStop) begin
                  n.ph = two_wire_pkg::PH_IDLE;
               end else if (busStart) begin
                  n.bitCnt = 4'h0;
               end else if (sclRise) begin
                  n.shft = {s.shft[6:0], s.sdaF};
                  n.bitCnt = s.bitCnt + 4'h1;
               end else if (sclFall && s.bitCnt == two_wire_pkg::BYTE_BITS) begin
                  // Address byte lives only in the shifter, never the data register
                  n.gcMode = s.shft[7:1] == two_wire_pkg::GC_ADDR && !s.shft[0];
                  // Recognition gated by ack enable and general call bit
                  if (s.ctrl[two_wire_pkg::CTL_ACK]
                      && (s.shft[7:1] == s.nodeAddr[7:1]
                          || (n.gcMode && s.nodeAddr[0]))) begin
                     n.ph = two_wire_pkg::PH_ADDR_ACK;
                     n.sdaOe = 1'b1;
                     n.txMode = s.shft[0];
                     n.gcMode = n.gcMode && s.shft[7:1] != s.nodeAddr[7:1];
                     if (s.sleepEn) begin
                        // Address seen asleep wakes the part
                        n.sleepEn = 1'b0;
                        n.woke = 1'b1;
                        n.wakeP = 1'b1;
                     end
                  end else begin
                     n.ph = two_wire_pkg::PH_IDLE;
                  end
               end
            end
            two_wire_pkg::PH_ADDR_ACK: begin
               if (sclFall) begin
                  n.sdaOe = 1'b0;
                  n.sclOe = 1'b1;
                  n.ph = two_wire_pkg::PH_HOLD;
                  n.ctrl[two_wire_pkg::CTL_INT] = 1'b1;
                  if (s.txMode) begin
                     n.status = s.arbHit ? two_wire_pkg::ST_TX_ARB
                                : two_wire_pkg::ST_TX_OWN;
                  end else if (s.gcMode) begin
                     n.status = s.arbHit ? two_wire_pkg::ST_GC_ARB : two_wire_pkg::ST_GC_OWN;
                  end else begin
                     n.status = s.arbHit ? two_wire_pkg::ST_SR_ARB : two_wire_pkg::ST_SR_OWN;
                  end
               end
            end
            two_wire_pkg::PH_RX: begin
               if (busStart || busStop) begin
                  // Bus released, so SCL is not held for this code
                  n.ph = two_wire_pkg::PH_HOLD;
                  n.status = two_wire_pkg::ST_STOP;
                  n.ctrl[two_wire_pkg::CTL_INT] = 1'b1;
               end else if (sclRise) begin
                  n.shft = {s.shft[6:0], s.sdaF};
                  n.bitCnt = s.bitCnt + 4'h1;
               end else if (sclFall && s.bitCnt == two_wire_pkg::BYTE_BITS) begin
                  n.rxAck = s.ctrl[two_wire_pkg::CTL_ACK];
                  n.sdaOe = s.ctrl[two_wire_pkg::CTL_ACK];
                  n.ph = two_wire_pkg::PH_RX_ACK;
               end
            end
            two_wire_pkg::PH_RX_ACK: begin
               if (sclFall) begin
                  n.sdaOe = 1'b0;
                  n.sclOe = 1'b1;
                  n.dataReg = s.shft;
                  n.ph = two_wire_pkg::PH_HOLD;
                  n.ctrl[two_wire_pkg::CTL_INT] = 1'b1;
                  if (s.gcMode) begin
                     n.status = s.rxAck ? two_wire_pkg::ST_GC_ACK
                                : two_wire_pkg::ST_GC_NACK;
                  end else begin
                     n.status = s.rxAck ? two_wire_pkg::ST_RX_ACK : two_wire_pkg::ST_RX_NACK;
                  end
               end
            end
            two_wire_pkg::PH_TX: begin
               if (busStart || busStop) begin
                  n.ph = two_wire_pkg::PH_IDLE;
                  n.sdaOe = 1'b0;
               end else if (sclFall) begin
                  n.shft = {s.shft[6:0], 1'b1};
                  n.bitCnt = s.bitCnt + 4'h1;
                  n.sdaOe = !s.shft[6];
                  if (s.bitCnt == two_wire_pkg::BYTE_BITS - 4'h1) begin
                     n.sdaOe = 1'b0;
                     n.ph = two_wire_pkg::PH_TX_ACK;
                  end
               end
            end
            two_wire_pkg::PH_TX_ACK: begin
               if (busStart || busStop) begin
                  n.ph = two_wire_pkg::PH_IDLE;
               end else if (sclRise) begin
                  n.rxAck = !s.sdaF;
               end else if (sclFall) begin
                  n.sclOe = 1'b1;
                  n.ph = two_wire_pkg::PH_HOLD;
                  n.ctrl[two_wire_pkg::CTL_INT] = 1'b1;
                  // Master ACK after the last byte still ends the transfer
                  n.status = !s.rxAck ? two_wire_pkg::ST_TX_NACK
                             : (s.txLast ? two_wire_pkg::ST_TX_LAST
                                : two_wire_pkg::ST_TX_ACK);
               end
            end
            two_wire_pkg::PH_HOLD: begin
               // SCL stays low until software writes the flag to one, except after 0xA0 where it is not held
               if (clrEvt) begin
                  n.sclOe = 1'b0;
                  n.bitCnt = 4'h0;
                  if (terminal) begin
                     // Further reads by the master see released SDA
                     n.ph = two_wire_pkg::PH_IDLE;
                     n.startPend = n.ctrl[two_wire_pkg::CTL_STA];
                  end else if (s.txMode) begin
                     n.ph = two_wire_pkg::PH_TX;
                     n.shft = s.dataReg;
                     n.sdaOe = !s.dataReg[7];
                     n.txLast = !n.ctrl[two_wire_pkg::CTL_ACK];
                  end else begin
                     n.ph = two_wire_pkg::PH_RX;
                  end
               end
            end
         endcase
      end
      // Start request is raised only on a free bus
      n.strq = n.startPend && !n.busy;
   end
   // ==============================
   // State register
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
         s.ph <= two_wire_pkg::PH_IDLE;
         s.sclS <= '1;
         s.sdaS <= '1;
         s.sclF <= 1'b1;
         s.sdaF <= 1'b1;
         s.nodeAddr <= two_wire_pkg::NODE_RST;
         s.ctrl <= two_wire_pkg::CTRL_RST;
         s.dataReg <= two_wire_pkg::DATA_RST;
         s.status <= two_wire_pkg::ST_NONE;
         s.waitQ <= 1'b1;
      end else begin
         s <= n;
      end
   end
   // Open-drain pins only ever pull low
   assign sclOut = 1'b0;
   assign sdaOut = 1'b0;
   assign sclOe = s.sclOe;
   assign sdaOe = s.sdaOe;
   assign avs_readdata = s.rdata;
   assign avs_waitrequest = s.waitQ;
   assign startRequest = s.strq;
   assign wakeUp = s.wakeP;
   // ==============================
   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   localparam int CTLE = two_wire_pkg::CTL_EN;
   a_gc_data_code: assert property (
      (s.ph == two_wire_pkg::PH_RX_ACK && sclFall && s.gcMode && s.rxAck && s.ctrl[CTLE])
      |=> s.status == two_wire_pkg::ST_GC_ACK && s.ctrl[two_wire_pkg::CTL_INT])
      else $error("general call data status wrong");
   a_terminal_exit: assert property (
      (s.ph == two_wire_pkg::PH_HOLD && clrEvt && terminal && s.ctrl[CTLE])
      |=> s.ph == two_wire_pkg::PH_IDLE && !s.sclOe)
      else $error("terminal state did not leave");
   a_ack_gates_addr: assert property (
      (s.ph == two_wire_pkg::PH_ADDR && !s.ctrl[two_wire_pkg::CTL_ACK])
      |=> s.ph != two_wire_pkg::PH_ADDR_ACK)
      else $error("address answered with ack disabled");
   a_gc_needs_bit: assert property (
      (s.ph == two_wire_pkg::PH_ADDR_ACK && $past(s.ph) == two_wire_pkg::PH_ADDR && s.gcMode)
      |-> $past(s.nodeAddr[0]))
      else $error("general call answered while disabled");
   a_addr_flag_set: assert property (
      (s.ph == two_wire_pkg::PH_ADDR_ACK && sclFall && s.ctrl[CTLE])
      |=> s.ctrl[two_wire_pkg::CTL_INT] && s.sclOe && s.ph == two_wire_pkg::PH_HOLD)
      else $error("flag not set after address");
   a_last_byte_code: assert property (
      (s.ph == two_wire_pkg::PH_TX_ACK && sclFall && s.txLast && s.rxAck && s.ctrl[CTLE])
      |=> s.status == two_wire_pkg::ST_TX_LAST)
      else $error("last byte ack code wrong");
   a_idle_sda_free: assert property (
      s.ph == two_wire_pkg::PH_IDLE |-> !s.sdaOe)
      else $error("SDA driven while unaddressed");
   a_hold_scl_low: assert property (
      (s.ctrl[two_wire_pkg::CTL_INT] && s.ctrl[CTLE] && s.status != two_wire_pkg::ST_STOP)
      |-> s.sclOe)
      else $error("SCL released before flag clear");
   a_wake_pulse: assert property (
      $rose(s.wakeP) |-> s.woke && !s.sleepEn ##1 !s.wakeP)
      else $error("wake pulse malformed");
   a_status_presc: assert property (
      (avs_read && s.waitQ && avs_address == two_wire_pkg::OFS_STAT)
      |=> s.rdata[2:0] == 3'h0 && !s.waitQ)
      else $error("prescaler bits not zero");
endmodule
`default_nettype wire

/* two_wire_slave_engine_fix.sv */
// Two-wire slave engine: no further logic is needed here

/* two_wire_master_model.sv */
// Behavioural two-wire bus master that faces the slave engine
`timescale 1ns/1ps
`default_nettype none
module two_wire_master_model (
   // Open-drain pulls, high while pulling the wire low
   output logic sclLow,
   output logic sdaLow,
   // Resolved wire levels
   input wire logic scl,
   input wire logic sda
);
   // ==============================
   // Quarter of the 48 ns bus clock period
   localparam realtime Q = 12.0;
   // Both lines released at start, pull-ups give idle high
   initial begin
      sclLow = 1'b0;
      sdaLow = 1'b0;
   end
   // One bit: data set while SCL low, sampled mid high phase
   task automatic bitXfer(input logic b, output logic s);
      sdaLow = ~b;
      #Q;
      sclLow = 1'b0;
      wait (scl === 1'b1); // A stretching slave delays the high phase
      #Q;
      s = sda;
      #Q;
      sclLow = 1'b1;
      #Q;
   endtask
   // SDA falls while SCL high
   task automatic start();
      sdaLow = 1'b1;
      #(2*Q);
      sclLow = 1'b1;
      #Q;
   endtask
   // SDA rises while SCL high, then the bus is left free
   task automatic stop();
      sdaLow = 1'b1;
      #Q;
      sclLow = 1'b0;
      wait (scl === 1'b1);
      #(2*Q);
      sdaLow = 1'b0;
      #(2*Q);
   endtask
   // Eight bits MSB first, then the acknowledge slot is read
   task automatic writeByte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitXfer(d[i], s);
      end
      bitXfer(1'b1, ack);
   endtask
   // Eight bits read with SDA released, then our own acknowledge
   task automatic readByte(input logic ackBit, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitXfer(1'b1, d[i]);
      end
      bitXfer(ackBit, s);
   endtask
endmodule
`default_nettype wire

/* two_wire_slave_engine_tb.sv */
// Self-checking bench for the two-wire slave engine
`timescale 1ns/1ps
`default_nettype none
module two_wire_slave_engine_tb;
   // ==============================
   // Signals
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [4:0] avsAddress = 5'h00;
   logic avsRead = 1'b0;
   logic avsWrite = 1'b0;
   logic [31:0] avsWritedata = 32'h0;
   logic arbLost = 1'b0;
   logic [31:0] avsReaddata;
   logic avsWaitrequest, sclOe, sdaOe, sclOut, sdaOut, mScl, mSda, startRequest, wakeUp;
   int err_total = 0;
   int checked = 0;
   int wakes = 0;
   logic [31:0] rng = 32'h0000_005D;
   // Open-drain wires with pull-ups
   wire sclW = ~mScl & (~sclOe | sclOut);
   wire sdaW = ~mSda & (~sdaOe | sdaOut);
   // 250 MHz system clock
   always #2 clk_sys = ~clk_sys;
   // Count wake pulses, they last one cycle only
   always @(posedge clk_sys) if (wakeUp === 1'b1) wakes <= wakes + 1;
   two_wire_slave_engine dut_u (.clk_sys(clk_sys), .resetn(resetn), .avs_address(avsAddress),
      .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
      .avs_byteenable(4'hF), .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
      .sclIn(sclW), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .arbLost(arbLost), .startRequest(startRequest), .wakeUp(wakeUp));
   two_wire_master_model m_u (.sclLow(mScl), .sdaLow(mSda), .scl(sclW), .sda(sdaW));
   // ==============================
   // Helpers
   function automatic logic [7:0] xorshift();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng[7:0];
   endfunction
   // Control byte that clears the flag, enable kept on
   function automatic logic [7:0] ctl(input logic ack, input logic sta);
      return {1'b1, ack, sta, 3'b001, 2'b00};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Avalon access held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
                      output logic [31:0] q);
      @(posedge clk_sys);
      avsAddress <= a;
      avsWritedata <= {24'h0, d};
      avsWrite <= wr;
      avsRead <= ~wr;
      do begin
         @(posedge clk_sys);
      end while (avsWaitrequest !== 1'b0);
      q = avsReaddata;
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rdChk(input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(q, exp);
   endtask
   // Poll the flag a bounded number of times, then check the status code
   task automatic flagStat(input logic [7:0] exp);
      logic [31:0] q;
      int n;
      n = 0;
      do begin
         bus(1'b0, two_wire_pkg::OFS_CTRL, 8'h00, q);
         n++;
      end while (q[7] !== 1'b1 && n < 400);
      rdChk(two_wire_pkg::OFS_STAT, {24'h0, exp});
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Watchdog well beyond the expected run of about 9 us
   initial begin
      #300000;
      err_total++;
      complete_run();
   end
   // ==============================
   // Main sequence
   initial begin
      logic [6:0] own;
      logic [7:0] d;
      logic [7:0] q8;
      logic ack;
      repeat (8) @(posedge clk_sys);
      resetn <= 1'b1;
      d = xorshift();
      own = {1'b1, d[5:0]}; // Never the general call address
      rdChk(two_wire_pkg::OFS_NODE, 32'h0);
      rdChk(two_wire_pkg::OFS_STAT, 32'hF8);
      rdChk(two_wire_pkg::OFS_DATA, 32'hFF);
      rdChk(5'h14, 32'h0);
      wr(two_wire_pkg::OFS_NODE, {own, 1'b1});
      rdChk(two_wire_pkg::OFS_NODE, {own, 1'b1});
      wr(two_wire_pkg::OFS_CTRL, 8'h44);
      // Own write address, then a refused byte with a start wanted
      m_u.start();
      m_u.writeByte({own, 1'b0}, ack);
      chk(ack, 0);
      flagStat(two_wire_pkg::ST_SR_OWN);
      wr(two_wire_pkg::OFS_CTRL, ctl(1'b0, 1'b0));
      d = xorshift();
      m_u.writeByte(d, ack);
      chk(ack, 1);
      flagStat(two_wire_pkg::ST_RX_NACK);
      rdChk(two_wire_pkg::OFS_DATA, d);
      wr(two_wire_pkg::OFS_CTRL, ctl(1'b1, 1'b1));
      repeat (2) @(posedge clk_sys);
      chk(startRequest, 0);
      m_u.stop();
      repeat (20) @(posedge clk_sys);
      chk(startRequest, 1);
      // General call: one byte taken, the next refused
      m_u.start();
      m_u.writeByte(8'h00, ack);
      chk(ack, 0);
      flagStat(two_wire_pkg::ST_GC_OWN);
      wr(two_wire_pkg::OFS_CTRL, ctl(1'b1, 1'b0));
      m_u.writeByte(xorshift(), ack);
      flagStat(two_wire_pkg::ST_GC_ACK);
      wr(two_wire_pkg::OFS_CTRL, ctl(1'b0, 1'b0));
      m_u.writeByte(xorshift(), ack);
      chk(ack, 1);
      flagStat(two_wire_pkg::ST_GC_NACK);
      wr(two_wire_pkg::OFS_CTRL, ctl(1'b0, 1'b0));
      m_u.stop();
      // Acknowledge off: own address ignored; then general call bit clear: general call ignored
      m_u.start();
      m_u.writeByte({own, 1'b0}, ack);
      chk(ack, 1);
      m_u.stop();
      wr(two_wire_pkg::OFS_NODE, {own, 1'b0});
      wr(two_wire_pkg::OFS_CTRL, 8'h44);
      m_u.start();
      m_u.writeByte(8'h00, ack);
      chk(ack, 1);
      m_u.stop();
      // STOP while still addressed as receiver
      m_u.start();
      m_u.writeByte({own, 1'b0}, ack);
      chk(ack, 0);
      flagStat(two_wire_pkg::ST_SR_OWN);
      wr(two_wire_pkg::OFS_CTRL, ctl(1'b1, 1'b0));
      m_u.stop();
      flagStat(two_wire_pkg::ST_STOP);
      wr(two_wire_pkg::OFS_CTRL, ctl(1'b1, 1'b0));
      // Last byte, master asks for more, then sees all ones
      m_u.start();
      m_u.writeByte({own, 1'b1}, ack);
      flagStat(two_wire_pkg::ST_TX_OWN);
      d = xorshift();
      wr(two_wire_pkg::OFS_DATA, d);
      wr(two_wire_pkg::OFS_CTRL, ctl(1'b0, 1'b0));
      m_u.readByte(1'b0, q8);
      chk(q8, d);
      flagStat(two_wire_pkg::ST_TX_LAST);
      wr(two_wire_pkg::OFS_CTRL, ctl(1'b1, 1'b0));
      m_u.readByte(1'b1, q8);
      chk(q8, 8'hFF);
      m_u.stop();
      // Lost arbitration, then addressed for reading
      m_u.start();
      @(posedge clk_sys) arbLost <= 1'b1;
      @(posedge clk_sys) arbLost <= 1'b0;
      m_u.writeByte({own, 1'b1}, ack);
      flagStat(two_wire_pkg::ST_TX_ARB);
      d = xorshift();
      wr(two_wire_pkg::OFS_DATA, d);
      wr(two_wire_pkg::OFS_CTRL, ctl(1'b1, 1'b0));
      m_u.readByte(1'b0, q8);
      chk(q8, d);
      flagStat(two_wire_pkg::ST_TX_ACK);
      d = xorshift();
      wr(two_wire_pkg::OFS_DATA, d);
      wr(two_wire_pkg::OFS_CTRL, ctl(1'b0, 1'b0));
      m_u.readByte(1'b1, q8);
      chk(q8, d);
      flagStat(two_wire_pkg::ST_TX_NACK);
      wr(two_wire_pkg::OFS_CTRL, ctl(1'b1, 1'b0));
      m_u.stop();
      // Data write with the flag clear is refused and flagged
      wr(two_wire_pkg::OFS_DATA, 8'h5A);
      rdChk(two_wire_pkg::OFS_CTRL, 32'h4C);
      rdChk(two_wire_pkg::OFS_DATA, d);
      // Asleep: address still matched, SCL held until flag cleared
      wr(two_wire_pkg::OFS_POWER, 8'h01);
      m_u.start();
      m_u.writeByte({own, 1'b0}, ack);
      chk(ack, 0);
      repeat (20) @(posedge clk_sys);
      chk(sclOe, 1);
      chk(wakes, 1);
      rdChk(two_wire_pkg::OFS_POWER, 32'h02);
      wr(two_wire_pkg::OFS_CTRL, ctl(1'b1, 1'b0));
      repeat (4) @(posedge clk_sys);
      chk(sclOe, 0);
      m_u.stop();
      complete_run();
   end
endmodule
`default_nettype wire
